// ===== inc/tic_params.svh
// Register map, field positions and reset values of the capture block
`ifndef TIC_PARAMS_SVH
`define TIC_PARAMS_SVH

`define TIC_NCHAN        4
`define TIC_IDX_W        4
`define TIC_IDX_CTRL0    4'h0
`define TIC_IDX_LATCH0   4'h4
`define TIC_IDX_LATCH_END 4'hB
`define TIC_IDX_DMASEL   4'hC

`define TIC_BIT_FLAG     7
`define TIC_BIT_IE       6
`define TIC_BIT_MSB      5
`define TIC_BIT_MSA      4
`define TIC_BIT_ELSB     3
`define TIC_BIT_ELSA     2
`define TIC_BIT_TOV      1
`define TIC_BIT_MAX      0

`define TIC_CTRL_RESET   8'h00
`define TIC_CTRL_WMASK   8'h7F
`define TIC_DMASEL_RESET 4'h0
`define TIC_SEL_LANE     0
`define TIC_PAIR_BIT     1

`endif

// ===== inc/tic_pkg.sv
// Types shared by the capture block modules
package tic_pkg;
  typedef logic [7:0]  tic_byte_t;
  typedef logic [15:0] tic_count_t;
  typedef logic [3:0]  tic_idx_t;

  typedef enum logic [2:0] {
    KIND_NONE = 3'b000,
    KIND_CTRL = 3'b001,
    KIND_HI   = 3'b010,
    KIND_LO   = 3'b011,
    KIND_DMA  = 3'b100
  } tic_kind_t;
endpackage

// ===== inc/tic_acc_if.sv
// Decoded register access between bus slave and channel core
`timescale 1ns/1ns
`default_nettype none
interface tic_acc_if;
  import tic_pkg::*;
  logic      acc;
  logic      we;
  logic      wen;
  tic_idx_t  idx;
  tic_byte_t wdat;
  tic_byte_t rdat;

  modport slave (output acc, we, wen, idx, wdat, input rdat);
  modport core  (input acc, we, wen, idx, wdat, output rdat);
endinterface
`default_nettype wire

// ===== core/tic_pin_sync.sv
// Three-stage pin synchroniser with agreed-level edge detection
`timescale 1ns/1ns
`default_nettype none
`include "tic_params.svh"
module tic_pin_sync
  import tic_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic [`TIC_NCHAN-1:0] pin_in,
  output var  logic [`TIC_NCHAN-1:0] rise_out,
  output var  logic [`TIC_NCHAN-1:0] fall_out
);
  logic [`TIC_NCHAN-1:0] s1_reg;
  logic [`TIC_NCHAN-1:0] s2_reg;
  logic [`TIC_NCHAN-1:0] s3_reg;
  logic [`TIC_NCHAN-1:0] lvl_reg;

  genvar gi;
  generate
    for (gi = 0; gi < `TIC_NCHAN; gi++) begin : g_bit
      always_ff @(posedge clk_in) begin
        s1_reg[gi] <= pin_in[gi];
        s2_reg[gi] <= s1_reg[gi];
        s3_reg[gi] <= s2_reg[gi];
      end

      // Level taken only once stages two and three agree
      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          lvl_reg[gi]  <= 1'b0;
          rise_out[gi] <= 1'b0;
          fall_out[gi] <= 1'b0;
        end else begin
          rise_out[gi] <= 1'b0;
          fall_out[gi] <= 1'b0;
          if (s2_reg[gi] == s3_reg[gi] && s3_reg[gi] != lvl_reg[gi]) begin
            lvl_reg[gi]  <= s3_reg[gi];
            rise_out[gi] <= s3_reg[gi];
            fall_out[gi] <= ~s3_reg[gi];
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ===== core/tic_wb_slave.sv
// Classic Wishbone slave front end, one access per request
`timescale 1ns/1ns
`default_nettype none
`include "tic_params.svh"
module tic_wb_slave
  import tic_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        cyc_in,
  input  wire logic        stb_in,
  input  wire logic        we_in,
  input  wire logic [5:0]  adr_in,
  input  wire logic [3:0]  sel_in,
  input  wire logic [31:0] dat_in,
  output var  logic [31:0] dat_out,
  output var  logic        ack_out,
  tic_acc_if.slave         bus
);
  // Access fires once; ack high blocks a second side effect
  assign bus.acc  = cyc_in & stb_in & ~ack_out;
  assign bus.we   = we_in;
  assign bus.wen  = we_in & sel_in[`TIC_SEL_LANE];
  assign bus.idx  = adr_in[5:2];
  assign bus.wdat = dat_in[7:0];

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ack_out <= 1'b0;
    end else begin
      ack_out <= bus.acc;
    end
  end

  // Narrow registers sit in the low lane, upper bits read zero
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      dat_out <= 32'h0000_0000;
    end else if (bus.acc && !we_in) begin
      dat_out <= {24'h00_0000, bus.rdat};
    end else begin
      dat_out <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// ===== core/tic_capture_top.sv
// Four input capture channels with Wishbone register access
`timescale 1ns/1ns
`default_nettype none
`include "tic_params.svh"
module tic_capture_top
  import tic_pkg::*;
(
  input  wire logic                  SYS_CLK_IN,
  input  wire logic                  RESET_N_IN,
  input  wire logic                  WB_CYC_IN,
  input  wire logic                  WB_STB_IN,
  input  wire logic                  WB_WE_IN,
  input  wire logic [5:0]            WB_ADR_IN,
  input  wire logic [3:0]            WB_SEL_IN,
  input  wire logic [31:0]           WB_DAT_IN,
  output var  logic [31:0]           WB_DAT_OUT,
  output var  logic                  WB_ACK_OUT,
  input  wire logic [15:0]           SHARED_COUNT_IN,
  input  wire logic [`TIC_NCHAN-1:0] CHAN_PIN_IN,
  output var  logic [`TIC_NCHAN-1:0] PIN_OWNED_OUT,
  output var  logic [`TIC_NCHAN-1:0] CPU_IRQ_OUT,
  output var  logic [`TIC_NCHAN-1:0] DMA_REQ_OUT
);
  tic_acc_if bus ();

  tic_byte_t             ctrl_reg [`TIC_NCHAN];
  tic_count_t            latch_reg [`TIC_NCHAN];
  logic [`TIC_NCHAN-1:0] armed_reg;
  logic [`TIC_NCHAN-1:0] lock_reg;
  logic [`TIC_NCHAN-1:0] dma_sel_reg;
  logic [`TIC_NCHAN-1:0] flag_next;
  logic [`TIC_NCHAN-1:0] chan_on;
  logic [`TIC_NCHAN-1:0] cap_mode;
  logic [`TIC_NCHAN-1:0] hit;
  logic [`TIC_NCHAN-1:0] rise;
  logic [`TIC_NCHAN-1:0] fall;

  tic_kind_t             kind;
  logic [1:0]            sel_ch;
  tic_idx_t              lat_off;

  tic_wb_slave u_slave (
    .clk_in   (SYS_CLK_IN),
    .rst_n_in (RESET_N_IN),
    .cyc_in   (WB_CYC_IN),
    .stb_in   (WB_STB_IN),
    .we_in    (WB_WE_IN),
    .adr_in   (WB_ADR_IN),
    .sel_in   (WB_SEL_IN),
    .dat_in   (WB_DAT_IN),
    .dat_out  (WB_DAT_OUT),
    .ack_out  (WB_ACK_OUT),
    .bus      (bus.slave)
  );

  tic_pin_sync u_sync (
    .clk_in   (SYS_CLK_IN),
    .rst_n_in (RESET_N_IN),
    .pin_in   (CHAN_PIN_IN),
    .rise_out (rise),
    .fall_out (fall)
  );

  // Word index to register kind and channel
  always_comb begin
    kind    = KIND_NONE;
    sel_ch  = 2'b00;
    lat_off = bus.idx - `TIC_IDX_LATCH0;
    if (bus.idx < `TIC_IDX_LATCH0) begin
      kind   = KIND_CTRL;
      sel_ch = bus.idx[1:0];
    end else if (bus.idx <= `TIC_IDX_LATCH_END) begin
      sel_ch = lat_off[2:1];
      if (lat_off[0]) begin
        kind = KIND_LO;
      end else begin
        kind = KIND_HI;
      end
    end else if (bus.idx == `TIC_IDX_DMASEL) begin
      kind = KIND_DMA;
    end
  end

  // Route select, one bit per channel
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RESET_N_IN) begin
      dma_sel_reg <= `TIC_DMASEL_RESET;
    end else if (bus.acc && bus.wen && kind == KIND_DMA) begin
      dma_sel_reg <= bus.wdat[`TIC_NCHAN-1:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `TIC_NCHAN; gi++) begin : g_ch
      localparam int PAIR = gi - (gi % 2);
      logic sel_here;
      logic ctrl_acc;
      logic hi_acc;
      logic lo_acc;
      logic pair_buf;
      logic any_edge;
      logic dma_mode;
      logic clr_cpu;
      logic clr_dma;

      assign sel_here = bus.acc && sel_ch == 2'(gi);
      assign ctrl_acc = sel_here && kind == KIND_CTRL;
      assign hi_acc   = sel_here && kind == KIND_HI;
      assign lo_acc   = sel_here && kind == KIND_LO;
      assign pair_buf = ctrl_reg[PAIR][`TIC_BIT_MSB];
      assign any_edge = ctrl_reg[gi][`TIC_BIT_ELSB]
                      | ctrl_reg[gi][`TIC_BIT_ELSA];

      // odd partner disabled by buffered bit
      if (gi % 2 == 1) begin : g_odd
        assign chan_on[gi] = ~pair_buf;
      end else begin : g_even
        assign chan_on[gi] = 1'b1;
      end

      // unbuffered bit acts only while pair bit clear
      // edge code 00 means no capture
      // toggle and full-duty bits not consulted
      assign cap_mode[gi] = chan_on[gi] & ~pair_buf
                          & ~ctrl_reg[gi][`TIC_BIT_MSA] & any_edge;

      // edge code picks rising, falling or both
      assign hit[gi] = cap_mode[gi]
                     & ((rise[gi] & ctrl_reg[gi][`TIC_BIT_ELSA])
                      | (fall[gi] & ctrl_reg[gi][`TIC_BIT_ELSB]));

      assign dma_mode = ctrl_reg[gi][`TIC_BIT_IE] & dma_sel_reg[gi];

      // zero write clears only after arming read
      // a one written to the flag is ignored
      assign clr_cpu = ctrl_acc && bus.wen && chan_on[gi]
                     && !bus.wdat[`TIC_BIT_FLAG]
                     && armed_reg[gi] && !dma_mode;

      // any low byte access clears in DMA mode
      assign clr_dma = lo_acc && dma_mode;

      // edge sets flag, set wins over a clear
      // same-cycle event beats the zero write
      assign flag_next[gi] = hit[gi]
                           | (ctrl_reg[gi][`TIC_BIT_FLAG]
                              & ~(clr_cpu | clr_dma));

      always_ff @(posedge SYS_CLK_IN) begin
        if (!RESET_N_IN) begin
          ctrl_reg[gi] <= `TIC_CTRL_RESET;
        end else begin
          ctrl_reg[gi][`TIC_BIT_FLAG] <= flag_next[gi];
          if (ctrl_acc && bus.wen && chan_on[gi]) begin
            ctrl_reg[gi][`TIC_BIT_IE]   <= bus.wdat[`TIC_BIT_IE];
            ctrl_reg[gi][`TIC_BIT_MSA]  <= bus.wdat[`TIC_BIT_MSA];
            ctrl_reg[gi][`TIC_BIT_ELSB] <= bus.wdat[`TIC_BIT_ELSB];
            ctrl_reg[gi][`TIC_BIT_ELSA] <= bus.wdat[`TIC_BIT_ELSA];
            ctrl_reg[gi][`TIC_BIT_TOV]  <= bus.wdat[`TIC_BIT_TOV];
            ctrl_reg[gi][`TIC_BIT_MAX]  <= bus.wdat[`TIC_BIT_MAX];
            // buffered bit only on even channels
            if (gi % 2 == 0) begin
              ctrl_reg[gi][`TIC_BIT_MSB] <= bus.wdat[`TIC_BIT_MSB];
            end
          end
        end
      end

      // an event after the arming read disarms the clear
      always_ff @(posedge SYS_CLK_IN) begin
        if (!RESET_N_IN) begin
          armed_reg[gi] <= 1'b0;
        end else if (hit[gi] || (ctrl_acc && bus.we)) begin
          armed_reg[gi] <= 1'b0;
        end else if (ctrl_acc && !bus.we && chan_on[gi]
                     && ctrl_reg[gi][`TIC_BIT_FLAG]) begin
          armed_reg[gi] <= 1'b1;
        end
      end

      // high byte read locks until low byte read
      always_ff @(posedge SYS_CLK_IN) begin
        if (!RESET_N_IN) begin
          lock_reg[gi] <= 1'b0;
        end else if (!cap_mode[gi]) begin
          lock_reg[gi] <= 1'b0;
        end else if (lo_acc && !bus.we) begin
          lock_reg[gi] <= 1'b0;
        end else if (hi_acc && !bus.we) begin
          lock_reg[gi] <= 1'b1;
        end
      end

      // Latch has no reset; contents undefined until used
      always_ff @(posedge SYS_CLK_IN) begin
        if (hi_acc && bus.wen) begin
          latch_reg[gi][15:8] <= bus.wdat;
        end else if (lo_acc && bus.wen) begin
          latch_reg[gi][7:0] <= bus.wdat;
        end else if (hit[gi] && !lock_reg[gi]) begin
          latch_reg[gi] <= SHARED_COUNT_IN;
        end
      end

      always_ff @(posedge SYS_CLK_IN) begin
        if (!RESET_N_IN) begin
          CPU_IRQ_OUT[gi] <= 1'b0;
          DMA_REQ_OUT[gi] <= 1'b0;
        end else begin
          CPU_IRQ_OUT[gi] <= chan_on[gi] & flag_next[gi]
                           & ctrl_reg[gi][`TIC_BIT_IE]
                           & ~dma_sel_reg[gi];
          DMA_REQ_OUT[gi] <= chan_on[gi] & flag_next[gi]
                           & ctrl_reg[gi][`TIC_BIT_IE]
                           & dma_sel_reg[gi];
        end
      end

      // pin handed to the port on code 00
      always_ff @(posedge SYS_CLK_IN) begin
        if (!RESET_N_IN) begin
          PIN_OWNED_OUT[gi] <= 1'b0;
        end else begin
          PIN_OWNED_OUT[gi] <= chan_on[gi] & any_edge;
        end
      end
    end
  endgenerate

  // Read mux; a disabled partner's control register reads as zero, its latch bytes still read back
  always_comb begin
    bus.rdat = 8'h00;
    unique case (kind)
      KIND_CTRL: begin
        if (chan_on[sel_ch]) begin
          bus.rdat = ctrl_reg[sel_ch];
        end
      end
      KIND_HI: begin
        bus.rdat = latch_reg[sel_ch][15:8];
      end
      KIND_LO: begin
        bus.rdat = latch_reg[sel_ch][7:0];
      end
      KIND_DMA: begin
        bus.rdat = {4'h0, dma_sel_reg};
      end
      KIND_NONE: begin
        bus.rdat = 8'h00;
      end
      default: begin
        bus.rdat = 8'h00;
      end
    endcase
  end
endmodule
`default_nettype wire

// ===== testbench/tic_pin_src.sv
// Pin source model for the four capture channel pins
`timescale 1ns/1ns
`default_nettype none
module tic_pin_src (
  input  wire logic       clk_in,
  output var  logic [3:0] pin_out
);
  initial pin_out = 4'h0;
  // stable before use
  // Levels move only on an edge, then hold for many clocks
  task automatic set(input int ch, input logic v);
    @(posedge clk_in);
    pin_out[ch] <= v;
  endtask
endmodule
`default_nettype wire

// ===== testbench/tic_capture_chk.sv
// Port-level properties of the capture block
`timescale 1ns/1ns
`default_nettype none
module tic_capture_chk (
  input wire logic        SYS_CLK_IN,
  input wire logic        RESET_N_IN,
  input wire logic        WB_CYC_IN,
  input wire logic        WB_STB_IN,
  input wire logic        WB_WE_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic        WB_ACK_OUT,
  input wire logic [3:0]  PIN_OWNED_OUT,
  input wire logic [3:0]  CPU_IRQ_OUT,
  input wire logic [3:0]  DMA_REQ_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  wire logic req = WB_CYC_IN && WB_STB_IN;
  wire logic wreq = req && WB_WE_IN;

  property p_ack_pulse; WB_ACK_OUT |=> !WB_ACK_OUT; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held too long");
  property p_ack_resp; req && !WB_ACK_OUT |=> WB_ACK_OUT; endproperty
  a_ack_resp: assert property (p_ack_resp)
    else $error("request not answered");
  property p_dat_hi; WB_DAT_OUT[31:8] == 24'h00_0000; endproperty
  a_dat_hi: assert property (p_dat_hi)
    else $error("read data upper bits set");
  property p_excl; (CPU_IRQ_OUT & DMA_REQ_OUT) == 4'h0; endproperty
  a_excl: assert property (p_excl)
    else $error("request on both routes");
  property p_rst;
    $rose(RESET_N_IN) |->
      !WB_ACK_OUT && (PIN_OWNED_OUT | CPU_IRQ_OUT | DMA_REQ_OUT) == 4'h0;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not cleared by reset");
  property p_own_chg;
    $changed(PIN_OWNED_OUT) |-> $past(wreq) || $past(wreq, 2);
  endproperty
  a_own_chg: assert property (p_own_chg)
    else $error("pin ownership moved without write");
  property p_irq_fall;
    ($past(CPU_IRQ_OUT) & ~CPU_IRQ_OUT) != 4'h0 |-> $past(req) || $past(req, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("cpu request dropped without access");
  property p_dma_fall;
    ($past(DMA_REQ_OUT) & ~DMA_REQ_OUT) != 4'h0 |-> $past(req) || $past(req, 2);
  endproperty
  a_dma_fall: assert property (p_dma_fall)
    else $error("dma request dropped without access");
endmodule

bind tic_capture_top tic_capture_chk tic_capture_chk_inst (
  .SYS_CLK_IN   (SYS_CLK_IN),
  .RESET_N_IN   (RESET_N_IN),
  .WB_CYC_IN    (WB_CYC_IN),
  .WB_STB_IN    (WB_STB_IN),
  .WB_WE_IN     (WB_WE_IN),
  .WB_DAT_OUT   (WB_DAT_OUT),
  .WB_ACK_OUT   (WB_ACK_OUT),
  .PIN_OWNED_OUT(PIN_OWNED_OUT),
  .CPU_IRQ_OUT  (CPU_IRQ_OUT),
  .DMA_REQ_OUT  (DMA_REQ_OUT)
);
`default_nettype wire

// ===== testbench/test_timer_input_capture_channels.sv
// Self-checking bench for the input capture channels
`timescale 1ns/1ns
`default_nettype none
module test_timer_input_capture_channels
  import tic_pkg::*;
;
  logic        clk, rst_n, cyc, stb, we, ack;
  logic [5:0]  adr;
  logic [3:0]  sel, pins, own, irq, dma;
  logic [31:0] wdat, rdat, got;
  logic [15:0] cnt;
  logic [1:0]  c;
  int          n_mismatch = 0;
  int          samples_checked = 0;

  tic_capture_top tic_capture_top_inst (
    .SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
    .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
    .SHARED_COUNT_IN(cnt), .CHAN_PIN_IN(pins), .PIN_OWNED_OUT(own),
    .CPU_IRQ_OUT(irq), .DMA_REQ_OUT(dma)
  );
  tic_pin_src tic_pin_src_inst (.clk_in(clk), .pin_out(pins));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic results();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask

  // Held until ack is sampled; released just after that edge
  task automatic acc(input logic w, input tic_idx_t i, input tic_byte_t d);
    int k;
    @(posedge clk);
    {cyc, stb, we, adr} <= {2'b11, w, i, 2'b00};
    wdat <= {24'h00_0000, d};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 16);
    if (ack !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] ack exp 1 got %b", ack);
    end
    got = rdat;
    {cyc, stb, we} <= 3'h0;
  endtask

  task automatic wr(input tic_idx_t i, input tic_byte_t d);
    acc(1'b1, i, d);
  endtask

  task automatic rc(input tic_idx_t i, input tic_byte_t e);
    acc(1'b0, i, 8'h00);
    chk($sformatf("reg%0d", i), {24'h00_0000, e}, got);
  endtask

  // Synchroniser needs a few clocks before the hit lands
  task automatic pe(input int ch, input logic v);
    tic_pin_src_inst.set(ch, v);
    repeat (8) @(posedge clk);
  endtask

  task automatic pp(input int ch);
    pe(ch, 1'b0);
    pe(ch, 1'b1);
  endtask

  initial begin
    {rst_n, cyc, stb, we, adr, wdat, cnt} = '0;
    sel = 4'h1;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 4; i++) rc(4'(i), 8'h00);
    rc(4'hC, 8'h00);
    rc(4'hD, 8'h00);
    wr(4'h2, 8'hDF);
    rc(4'h2, 8'h5F);
    wr(4'h1, 8'h2C);
    rc(4'h1, 8'h0C);
    wr(4'h0, 8'h20);
    rc(4'h1, 8'h00);
    chk("own1", 32'(own[1]), 32'h0);
    wr(4'h1, 8'h04);
    wr(4'h0, 8'h00);
    rc(4'h1, 8'h0C);
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h00);
    for (int n = 0; n < 4; n++) begin
      c = 2'(n);
      wr(4'h2, {4'h0, c, 2'b00});
      pe(2, 1'b1);
      chk("own2", 32'(c != 2'b00), 32'(own[2]));
      rc(4'h2, {c[0], 3'h0, c, 2'b00});
      wr(4'h2, {4'h0, c, 2'b00});
      pe(2, 1'b0);
      rc(4'h2, {c[1], 3'h0, c, 2'b00});
      wr(4'h2, 8'h00);
    end
    wr(4'h0, 8'h47);
    cnt <= 16'hA5C3;
    pe(0, 1'b1);
    chk("irq0", 32'(irq[0]), 32'h1);
    chk("dma0", 32'(dma[0]), 32'h0);
    rc(4'h4, 8'hA5);
    cnt <= 16'h1111;
    pp(0);
    rc(4'h5, 8'hC3);
    cnt <= 16'h2222;
    pp(0);
    rc(4'h4, 8'h22);
    rc(4'h5, 8'h22);
    rc(4'h0, 8'hC7);
    pp(0);
    wr(4'h0, 8'h47);
    rc(4'h0, 8'hC7);
    wr(4'h0, 8'h47);
    rc(4'h0, 8'h47);
    chk("irq0", 32'(irq[0]), 32'h0);
    wr(4'hC, 8'h01);
    cnt <= 16'h3333;
    pp(0);
    chk("dma0", 32'(dma[0]), 32'h1);
    chk("irq0", 32'(irq[0]), 32'h0);
    rc(4'h0, 8'hC7);
    wr(4'h0, 8'h47);
    rc(4'h0, 8'hC7);
    rc(4'h5, 8'h33);
    rc(4'h0, 8'h47);
    chk("dma0", 32'(dma[0]), 32'h0);
    wr(4'hC, 8'h00);
    wr(4'h4, 8'h9A);
    wr(4'h5, 8'hBC);
    rc(4'h4, 8'h9A);
    rc(4'h5, 8'hBC);
    cnt <= 16'h0000;
    wr(4'h0, 8'h57);
    pp(0);
    rc(4'h0, 8'h57);
    rc(4'h4, 8'h9A);
    results();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results();
  end
endmodule
`default_nettype wire
